// [sim/lls_host_model.sv]
/*
 * Host side of the status bank's read port: issues single-byte reads.
 * Assumes lls_params.svh on the include path and a free-running core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lls_params.svh"

module lls_host_model (
  input  wire logic               core_clk,
  output logic                    rd_en,
  output logic [`LLS_AW-1:0]      rd_addr
);

  initial begin
    rd_en = 1'b0;
    rd_addr = '0;
  end

  // Request held from one edge to the next; address scrambled once released
  task automatic rd(input logic [`LLS_AW-1:0] a);
    @(posedge core_clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
  endtask : rd

endmodule : lls_host_model
`default_nettype wire

// [sim/tb_top.sv]
/*
 * Self-checking bench of the status bank: levels, fault flags, selective wake.
 * Assumes lls_params.svh on the include path and lls_host_model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lls_params.svh"

module tb_top
  import lls_pkg::*;
;
  logic                 core_clk;
  logic                 reset;
  lls_pins_t            pins;
  logic [3:0]           hs_overload;
  logic [3:0]           hs_open_load;
  lls_swk_evt_t         swk_evt;
  logic                 selective_wake_system_error_clr;
  logic                 can_timeout_flag_clr;
  logic                 rd_en;
  logic [`LLS_AW-1:0]   rd_addr;
  logic [`LLS_DW-1:0]   rd_data;
  logic                 rd_valid;
  logic                 sw_err;
  logic                 can_to;
  logic                 sw_act;
  int                   mismatches = 0;
  int                   comparisons = 0;
  int                   cyc = 0;
  logic [7:0]           exp_q[$];
  logic [31:0]          rnd;
  logic [7:0]           lvl_e;

  lls_status_bank lls_status_bank_i (
    .core_clk(core_clk), .reset(reset), .pins(pins), .hs_overload(hs_overload),
    .hs_open_load(hs_open_load), .swk_evt(swk_evt), .selective_wake_system_error_clr(selective_wake_system_error_clr),
    .can_timeout_flag_clr(can_timeout_flag_clr), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .selective_wake_system_error(sw_err),
    .can_timeout_flag(can_to), .selective_wake_active(sw_act));

  lls_host_model lls_host_model_i (.core_clk(core_clk), .rd_en(rd_en), .rd_addr(rd_addr));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : cmp8

  task automatic cmp1(input string n, input logic e, input logic s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask : cmp1

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    lls_host_model_i.rd(a);
  endtask : chk_rd

  task automatic final_report;
    $display("Counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Read results against the oldest note
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() > 0)
        cmp8("rd_data", exp_q.pop_front(), rd_data);
      else
        cmp8("rd_data unrequested", 8'h00, 8'hxx);
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      $display("Error run_length expected below 3000 seen %0d", cyc);
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1; pins = '0; hs_overload = '0; hs_open_load = '0; swk_evt = '0;
    selective_wake_system_error_clr = 1'b0; can_timeout_flag_clr = 1'b0; rnd = 32'hc696; lvl_e = 8'h00;
    tick(12);
    reset <= 1'b0;
    chk_rd(`LLS_ADDR_LVL, 8'h00);
    chk_rd(`LLS_ADDR_OVL, 8'h00);
    chk_rd(`LLS_ADDR_OPL, 8'h00);
    chk_rd(`LLS_ADDR_SWK, 8'h00);
    chk_rd(7'h49, 8'h00);
    // Random levels over random static pin setups and modes
    for (int i = 0; i < 16; i++) begin
      rnd = xs(rnd);
      pins.wk_lvl <= rnd[2:0];
      pins.gp_lvl <= rnd[4:3];
      pins.gp_cfg[0] <= lls_gp_cfg_t'(rnd[6:5]);
      pins.gp_cfg[1] <= lls_gp_cfg_t'(rnd[8:7]);
      pins.sbc_mode <= lls_sbc_mode_t'(rnd[10:9]);
      pins.mode_select_pin <= rnd[11];
      pins.pullup_detect <= rnd[12];
      for (int g = 0; g < 2; g++)
        if (rnd[10:9] inside {2'd1, 2'd2} && rnd[5+2*g +: 2] != 2'd0) lvl_e[4+g] = rnd[3+g];
      lvl_e = {rnd[11], rnd[12], lvl_e[5:4], 1'b0, rnd[2:0]};
      tick(2);
      chk_rd(`LLS_ADDR_LVL, lvl_e);
    end
    // Cyclic sensing: level taken only at the sample
    pins.wk_cyclic <= 3'b111;
    pins.wk_lvl <= ~lvl_e[2:0];
    tick(2);
    chk_rd(`LLS_ADDR_LVL, lvl_e);
    pins.wk_sample <= 3'b101;
    tick(1);
    pins.wk_sample <= 3'b000;
    lvl_e[2:0] = {~lvl_e[2], lvl_e[1], ~lvl_e[0]};
    tick(1);
    chk_rd(`LLS_ADDR_LVL, lvl_e);
    // Fault flags, with a set landing on the clearing read
    for (int k = 0; k < 2; k++) begin
      rnd = xs(rnd);
      if (k == 0) hs_overload <= rnd[3:0] | 4'h8;
      else hs_open_load <= rnd[3:0] | 4'h8;
      tick(1);
      hs_overload <= '0;
      hs_open_load <= '0;
      fork
        chk_rd(k ? `LLS_ADDR_OPL : `LLS_ADDR_OVL, {4'h0, rnd[3:0] | 4'h8});
        begin
          tick(1);
          if (k == 0) hs_overload <= 4'h1;
          else hs_open_load <= 4'h1;
          tick(1);
          hs_overload <= '0;
          hs_open_load <= '0;
        end
      join
      chk_rd(k ? `LLS_ADDR_OPL : `LLS_ADDR_OVL, 8'h01);
      chk_rd(k ? `LLS_ADDR_OPL : `LLS_ADDR_OVL, 8'h00);
    end
    hs_overload <= 4'hf;
    tick(1);
    hs_overload <= '0;
    reset <= 1'b1;
    tick(1);
    reset <= 1'b0;
    chk_rd(`LLS_ADDR_OVL, 8'h00);
    // Selective wake activation and its events
    swk_evt.config_valid <= 1'b1;
    swk_evt.can_mode <= 3'b110;
    swk_evt.can_mode_wr <= 1'b1;
    tick(1);
    swk_evt.can_mode_wr <= 1'b0;
    tick(1);
    cmp1("selective_wake_active", 1'b1, sw_act);
    swk_evt.frame_ok <= 1'b1;
    swk_evt.wup_det <= 1'b1;
    tick(1);
    swk_evt.frame_ok <= 1'b0;
    swk_evt.wup_det <= 1'b0;
    chk_rd(`LLS_ADDR_SWK, 8'h46);
    swk_evt.wuf_det <= 1'b1;
    swk_evt.silence_exceeded <= 1'b1;
    tick(1);
    swk_evt.wuf_det <= 1'b0;
    tick(2);
    chk_rd(`LLS_ADDR_SWK, 8'h4f);
    cmp1("can_timeout_flag", 1'b1, can_to);
    swk_evt.can_mode <= 3'b100;
    swk_evt.can_mode_wr <= 1'b1;
    tick(1);
    swk_evt.can_mode_wr <= 1'b0;
    swk_evt.silence_exceeded <= 1'b0;
    tick(2);
    chk_rd(`LLS_ADDR_SWK, 8'h03);
    cmp1("can_timeout_flag", 1'b1, can_to);
    // System error blocks activation until cleared
    can_timeout_flag_clr <= 1'b1;
    swk_evt.cfg_error <= 1'b1;
    tick(1);
    can_timeout_flag_clr <= 1'b0;
    swk_evt.cfg_error <= 1'b0;
    swk_evt.can_mode <= 3'b110;
    swk_evt.can_mode_wr <= 1'b1;
    tick(1);
    swk_evt.can_mode_wr <= 1'b0;
    tick(1);
    cmp1("selective_wake_system_error", 1'b1, sw_err);
    cmp1("selective_wake_active", 1'b0, sw_act);
    selective_wake_system_error_clr <= 1'b1;
    swk_evt.can_mode_wr <= 1'b1;
    tick(1);
    selective_wake_system_error_clr <= 1'b0;
    swk_evt.can_mode_wr <= 1'b0;
    tick(1);
    swk_evt.can_mode_wr <= 1'b1;
    tick(1);
    swk_evt.can_mode_wr <= 1'b0;
    tick(1);
    cmp1("selective_wake_active", 1'b1, sw_act);
    chk_rd(`LLS_ADDR_SWK, 8'h04);
    swk_evt.ecnt_overflow <= 1'b1;
    tick(1);
    swk_evt.ecnt_overflow <= 1'b0;
    tick(2);
    cmp1("selective_wake_system_error", 1'b1, sw_err);
    cmp1("selective_wake_active", 1'b0, sw_act);
    selective_wake_system_error_clr <= 1'b1;
    tick(1);
    selective_wake_system_error_clr <= 1'b0;
    // Every mode code: only wake-mode codes other than 100 activate
    for (int m = 0; m < 8; m++) begin
      swk_evt.can_mode <= 3'b100;
      swk_evt.can_mode_wr <= 1'b1;
      tick(1);
      swk_evt.can_mode <= 3'(m);
      tick(1);
      swk_evt.can_mode_wr <= 1'b0;
      tick(2);
      cmp1("selective_wake_active", 1'(m > 4), sw_act);
    end
    tick(4);
    final_report();
  end

endmodule : tb_top
`default_nettype wire

// [src/lls_cof_flags.sv]
/*
 * Sticky clear-on-read flag group; a set in the clearing cycle wins.
 * Assumes set pulses and the clear strobe are synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lls_params.svh"

module lls_cof_flags
  import lls_pkg::*;
#(
  parameter int W = `LLS_NUM_HS
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] set,
  input  wire logic         clr,
  output logic      [W-1:0] q
);

  logic [W-1:0] flag_r;
  logic [W-1:0] flag_nxt;

  // Restart leaves these untouched; reset clears them, and so does the clear strobe for bits with no set
  always_comb begin
    flag_nxt = (flag_r & ~{W{clr}}) | set;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign q = flag_r;

  a_flag_set_wins: assert property (@(posedge core_clk) disable iff (reset)
    (set != '0) |=> ((q & $past(set)) == $past(set)))
    else $error("flag set lost");

endmodule : lls_cof_flags

`default_nettype wire

// [src/lls_level_hold.sv]
/*
 * Level holder: each bit takes its input only while its update enable is high.
 * Assumes inputs synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module lls_level_hold
  import lls_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] upd,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] q
);

  logic [W-1:0] lvl_r;
  logic [W-1:0] lvl_nxt;

  always_comb begin
    lvl_nxt = (lvl_r & ~upd) | (din & upd);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lvl_r <= '0;
    end else begin
      lvl_r <= lvl_nxt;
    end
  end

  assign q = lvl_r;

endmodule : lls_level_hold

`default_nettype wire

// [src/lls_params.svh]
/*
 * Constants of the level, switch-fault and selective-wake status bank.
 * Assumes nothing about its surroundings; it holds definitions only.
 */
`ifndef LLS_PARAMS_SVH
`define LLS_PARAMS_SVH

`define LLS_AW             7
`define LLS_DW             8
`define LLS_NUM_WK         3
`define LLS_NUM_GP         2
`define LLS_NUM_HS         4

`define LLS_ADDR_LVL       7'h48
`define LLS_ADDR_OVL       7'h54
`define LLS_ADDR_OPL       7'h55
`define LLS_ADDR_SWK       7'h70

`define LLS_DATA_RST       8'h00
`define LLS_FLAG_RST       4'h0
`define LLS_CAN_MODE_NOSWK 3'h4
`define LLS_CAN_SWK_BIT    2

`endif

// [src/lls_pkg.sv]
/*
 * Types of the status bank: pin groups, event groups and register layouts.
 * Assumes lls_params.svh is on the include path.
 */
`include "lls_params.svh"

package lls_pkg;

  typedef enum logic [1:0] {gp_cfg_off, gp_cfg_wake, gp_cfg_low_side, gp_cfg_high_side} lls_gp_cfg_t;
  typedef enum logic [1:0] {sbc_init, sbc_normal, sbc_stop, sbc_sleep} lls_sbc_mode_t;
  typedef enum logic {swk_off, swk_active} lls_swk_state_t;

  typedef struct packed {
    logic [`LLS_NUM_WK-1:0] wk_lvl;
    logic [`LLS_NUM_WK-1:0] wk_cyclic;
    logic [`LLS_NUM_WK-1:0] wk_sample;
    logic [`LLS_NUM_GP-1:0] gp_lvl;
    lls_gp_cfg_t [`LLS_NUM_GP-1:0] gp_cfg;
    lls_sbc_mode_t          sbc_mode;
    logic                   mode_select_pin;
    logic                   pullup_detect;
  } lls_pins_t;

  typedef struct packed {
    logic       can_mode_wr;
    logic [2:0] can_mode;
    logic       config_valid;
    logic       cfg_error;
    logic       ecnt_overflow;
    logic       frame_ok;
    logic       silence_exceeded;
    logic       wup_det;
    logic       wuf_det;
  } lls_swk_evt_t;

  typedef struct packed {
    logic                   development_mode_flag;
    logic                   pullup_config_flag;
    logic [`LLS_NUM_GP-1:0] gp_level;
    logic                   rsv3;
    logic [`LLS_NUM_WK-1:0] wake_level;
  } lls_lvl_reg_t;

  typedef struct packed {
    logic [3:0]             rsv;
    logic [`LLS_NUM_HS-1:0] hs;
  } lls_flag_reg_t;

  typedef struct packed {
    logic       rsv7;
    logic       sync;
    logic [1:0] rsv5_4;
    logic       bus_silence_exceeded;
    logic       selective_wake_active;
    logic       wake_pattern_seen;
    logic       wake_frame_seen;
  } lls_swk_reg_t;

endpackage : lls_pkg

// [src/lls_status_bank.sv]
/*
 * Status bank: input levels, high-side fault flags and selective wake status,
 * read byte-wide at their register addresses through the serial core's read port.
 * Assumes the serial core gives a one-cycle read strobe with the address, and
 * that all pin levels and events are already synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lls_params.svh"

module lls_status_bank
  import lls_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire lls_pins_t             pins,
  input  wire logic [`LLS_NUM_HS-1:0] hs_overload,
  input  wire logic [`LLS_NUM_HS-1:0] hs_open_load,
  input  wire lls_swk_evt_t          swk_evt,
  input  wire logic                  selective_wake_system_error_clr,
  input  wire logic                  can_timeout_flag_clr,
  input  wire logic                  rd_en,
  input  wire logic [`LLS_AW-1:0]    rd_addr,
  output logic      [`LLS_DW-1:0]    rd_data,
  output logic                       rd_valid,
  output logic                       selective_wake_system_error,
  output logic                       can_timeout_flag,
  output logic                       selective_wake_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Input levels

  logic [`LLS_NUM_WK-1:0] wk_upd;
  logic [`LLS_NUM_GP-1:0] gp_upd;
  logic [`LLS_NUM_WK-1:0] wk_q;
  logic [`LLS_NUM_GP-1:0] gp_q;
  logic                   dev_r;
  logic                   dev_nxt;
  logic                   pullup_r;
  logic                   pullup_nxt;
  logic                   gp_run_mode;

  always_comb begin
    // Static sense follows the pin; cyclic sense only on its sample
    wk_upd      = ~pins.wk_cyclic | pins.wk_sample;
    gp_run_mode = (pins.sbc_mode == sbc_normal) || (pins.sbc_mode == sbc_stop);
    for (int i = 0; i < `LLS_NUM_GP; i++) begin
      // No sample strobe here: general pins are never cyclic
      gp_upd[i] = gp_run_mode && (pins.gp_cfg[i] != gp_cfg_off);
    end
    dev_nxt    = pins.mode_select_pin;
    pullup_nxt = pins.pullup_detect;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dev_r    <= 1'b0;
      pullup_r <= 1'b0;
    end else begin
      dev_r    <= dev_nxt;
      pullup_r <= pullup_nxt;
    end
  end

  lls_level_hold #(.W(`LLS_NUM_WK)) u_wk_hold (
    .core_clk (core_clk),
    .reset    (reset),
    .upd      (wk_upd),
    .din      (pins.wk_lvl),
    .q        (wk_q)
  );

  lls_level_hold #(.W(`LLS_NUM_GP)) u_gp_hold (
    .core_clk (core_clk),
    .reset    (reset),
    .upd      (gp_upd),
    .din      (pins.gp_lvl),
    .q        (gp_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // High-side fault flags

  logic                   ovl_clr;
  logic                   opl_clr;
  logic [`LLS_NUM_HS-1:0] ovl_q;
  logic [`LLS_NUM_HS-1:0] opl_q;

  assign ovl_clr = rd_en && (rd_addr == `LLS_ADDR_OVL);
  assign opl_clr = rd_en && (rd_addr == `LLS_ADDR_OPL);

  lls_cof_flags #(.W(`LLS_NUM_HS)) u_ovl_flags (
    .core_clk (core_clk),
    .reset    (reset),
    .set      (hs_overload),
    .clr      (ovl_clr),
    .q        (ovl_q)
  );

  lls_cof_flags #(.W(`LLS_NUM_HS)) u_opl_flags (
    .core_clk (core_clk),
    .reset    (reset),
    .set      (hs_open_load),
    .clr      (opl_clr),
    .q        (opl_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Selective wake

  lls_swk_state_t swk_state_r;
  lls_swk_state_t swk_state_nxt;
  logic           swk_mode_bit;
  logic           swk_ok;
  logic           swk_start;
  logic           selective_wake_system_error_r;
  logic           selective_wake_system_error_nxt;
  logic           sync_r;
  logic           sync_nxt;
  logic           bus_silence_exceeded_r;
  logic           bus_silence_exceeded_nxt;
  logic           can_timeout_flag_r;
  logic           can_timeout_flag_nxt;
  logic           wup_r;
  logic           wup_nxt;
  logic           wuf_r;
  logic           wuf_nxt;

  always_comb begin
    swk_mode_bit  = swk_evt.can_mode[`LLS_CAN_SWK_BIT];
    swk_ok        = !selective_wake_system_error_r && swk_evt.config_valid && swk_mode_bit;
    swk_start     = swk_evt.can_mode_wr && (swk_evt.can_mode != `LLS_CAN_MODE_NOSWK);
    swk_state_nxt = swk_state_r;
    case (swk_state_r)
      swk_off: begin
        if (swk_start && swk_ok) begin
          swk_state_nxt = swk_active;
        end
      end
      swk_active: begin
        if (!swk_ok || (swk_evt.can_mode_wr && !swk_start)) begin
          swk_state_nxt = swk_off;
        end
      end
      default: begin
        swk_state_nxt = swk_off;
      end
    endcase
    // Error only tracked while wake mode bit is set; set beats clear
    selective_wake_system_error_nxt = (selective_wake_system_error_r && !selective_wake_system_error_clr) ||
                 (swk_mode_bit && (swk_evt.cfg_error || swk_evt.ecnt_overflow));
    sync_nxt   = (swk_state_r == swk_active) && (sync_r || swk_evt.frame_ok);
    bus_silence_exceeded_nxt = (swk_state_r == swk_active) && swk_evt.silence_exceeded;
    can_timeout_flag_nxt  = (can_timeout_flag_r && !can_timeout_flag_clr) || (swk_mode_bit && bus_silence_exceeded_r);
    // A fresh activation starts with clean detection bits
    wup_nxt    = (wup_r && !(swk_state_nxt == swk_active && swk_state_r == swk_off)) ||
                 swk_evt.wup_det;
    wuf_nxt    = (wuf_r && !(swk_state_nxt == swk_active && swk_state_r == swk_off)) ||
                 swk_evt.wuf_det;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      swk_state_r <= swk_off;
      selective_wake_system_error_r    <= 1'b0;
      sync_r      <= 1'b0;
      bus_silence_exceeded_r    <= 1'b0;
      can_timeout_flag_r     <= 1'b0;
      wup_r       <= 1'b0;
      wuf_r       <= 1'b0;
    end else begin
      swk_state_r <= swk_state_nxt;
      selective_wake_system_error_r    <= selective_wake_system_error_nxt;
      sync_r      <= sync_nxt;
      bus_silence_exceeded_r    <= bus_silence_exceeded_nxt;
      can_timeout_flag_r     <= can_timeout_flag_nxt;
      wup_r       <= wup_nxt;
      wuf_r       <= wuf_nxt;
    end
  end

  assign selective_wake_system_error = selective_wake_system_error_r;
  assign can_timeout_flag            = can_timeout_flag_r;
  assign selective_wake_active       = (swk_state_r == swk_active);

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  lls_lvl_reg_t             lvl_view;
  lls_flag_reg_t            ovl_view;
  lls_flag_reg_t            opl_view;
  lls_swk_reg_t             swk_view;
  logic [`LLS_DW-1:0]       rd_data_r;
  logic [`LLS_DW-1:0]       rd_data_nxt;
  logic                     rd_valid_r;

  always_comb begin
    lvl_view = '{development_mode_flag: dev_r, pullup_config_flag: pullup_r,
                 gp_level: gp_q, rsv3: 1'b0, wake_level: wk_q};
    ovl_view = '{rsv: `LLS_FLAG_RST, hs: ovl_q};
    opl_view = '{rsv: `LLS_FLAG_RST, hs: opl_q};
    swk_view = '{rsv7: 1'b0, sync: sync_r, rsv5_4: 2'h0, bus_silence_exceeded: bus_silence_exceeded_r,
                 selective_wake_active: (swk_state_r == swk_active),
                 wake_pattern_seen: wup_r, wake_frame_seen: wuf_r};
    rd_data_nxt = rd_data_r;
    if (rd_en) begin
      case (rd_addr)
        `LLS_ADDR_LVL: rd_data_nxt = lvl_view;
        `LLS_ADDR_OVL: rd_data_nxt = ovl_view;
        `LLS_ADDR_OPL: rd_data_nxt = opl_view;
        `LLS_ADDR_SWK: rd_data_nxt = swk_view;
        default:       rd_data_nxt = `LLS_DATA_RST;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_data_r  <= `LLS_DATA_RST;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_en;
    end
  end

  assign rd_data  = rd_data_r;
  assign rd_valid = rd_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_wk_static_follow: assert property (!pins.wk_cyclic[0] |=> wk_q[0] == $past(pins.wk_lvl[0]))
    else $error("static wake level not followed");
  a_wk_cyclic_hold: assert property ((pins.wk_cyclic[1] && !pins.wk_sample[1]) |=> $stable(wk_q[1]))
    else $error("cyclic wake level changed without sample");
  a_gp_switch_show: assert property ((pins.sbc_mode == sbc_stop && pins.gp_cfg[1] == gp_cfg_high_side)
    |=> gp_q[1] == $past(pins.gp_lvl[1]))
    else $error("general pin level not shown as switch");
  a_gp_off_frozen: assert property ((pins.gp_cfg[0] == gp_cfg_off || pins.sbc_mode == sbc_sleep)
    |=> $stable(gp_q[0]))
    else $error("general pin level moved while not refreshed");
  a_lvl_read_straps: assert property ((rd_en && rd_addr == `LLS_ADDR_LVL)
    |=> rd_valid && rd_data[7] == $past(dev_r) && rd_data[6] == $past(pullup_r) && rd_data[3] == 1'b0)
    else $error("level register strap bits wrong");
  a_ovl_read_clear: assert property ((rd_en && rd_addr == `LLS_ADDR_OVL)
    |=> rd_data == {4'h0, $past(ovl_q)} && ovl_q == $past(hs_overload))
    else $error("overload read or clear wrong");
  a_opl_read_clear: assert property ((rd_en && rd_addr == `LLS_ADDR_OPL)
    |=> rd_data[7:4] == 4'h0 && opl_q == $past(hs_open_load) ##1 opl_q == ($past(hs_open_load) | opl_q))
    else $error("open load read or clear wrong");
  a_swk_active_cond: assert property (selective_wake_active |-> $past(swk_ok))
    else $error("selective wake active without its conditions");
  a_swk_no_mode100: assert property ((swk_state_r == swk_off && swk_evt.can_mode_wr &&
    swk_evt.can_mode == `LLS_CAN_MODE_NOSWK) |=> swk_state_r == swk_off)
    else $error("mode 100 activated selective wake");
  a_sync_after_frame: assert property ($rose(sync_r) |-> $past(swk_evt.frame_ok))
    else $error("sync without error free frame");
  a_bus_silence_exceeded_cause: assert property (bus_silence_exceeded_r |-> $past(swk_evt.silence_exceeded && selective_wake_active))
    else $error("silence bit without cause");
  a_selective_wake_system_error_set: assert property ((swk_mode_bit && swk_evt.ecnt_overflow) |=> selective_wake_system_error_r)
    else $error("system error not set");
  a_can_timeout_flag_sticky: assert property ((swk_mode_bit && bus_silence_exceeded_r) |=> can_timeout_flag_r ##1 (can_timeout_flag_r || $past(can_timeout_flag_clr)))
    else $error("timeout flag not set or not held");
  a_wuf_set: assert property (swk_evt.wuf_det |=> wuf_r)
    else $error("wake frame not flagged");

  c_swk_activate: cover property (swk_state_r == swk_off ##1 swk_state_r == swk_active);
  c_ovl_clear_race: cover property (rd_en && rd_addr == `LLS_ADDR_OVL && hs_overload != '0);
  c_can_timeout_flag_set: cover property ($rose(can_timeout_flag_r));
  c_sync_seen: cover property ($rose(sync_r));

endmodule : lls_status_bank

`default_nettype wire
